// ===== rtl/tt_timer_two_map.vh
/*
 * Constants of the timer two control block: register addresses, field
 * positions, reset values and clock divide counts.
 * Assumes inclusion by bare name from the design files of this block only.
 */
`ifndef TT_TIMER_TWO_MAP_VH
`define TT_TIMER_TWO_MAP_VH

// Notes on behaviour
// [RULE_01] high overflow flag sets when the upper byte rolls 0xff to 0x00.
// [RULE_02] outside split mode the high flag sets when 0xffff wraps to 0x0000.
// [RULE_03] with the timer interrupt enabled, a set bit 7 requests an interrupt.
// [RULE_04] flags are never cleared by hardware; software writes zero to clear.
// [RULE_05] low overflow flag bit 6 sets on every low byte wrap, any mode.
// [RULE_06] bit 5 plus timer interrupt enable makes low overflows request too.
// [RULE_07] bit 4 one enables capture mode, zero disables it.
// [RULE_08] bit 3 zero: one 16-bit reload counter; one: two 8-bit counters.
// [RULE_09] run bit 2 at one lets the timer count, zero stops it.
// [RULE_10] in split mode run gates only the upper byte; lower byte always counts.
// [RULE_11] bit 1 is unused, reads zero, writes are ignored.
// [RULE_12] bit 0 zero picks system clock / 12, one picks synced external / 8.
// [RULE_13] in split mode the external select applies to both bytes.
// [RULE_14] per-byte selects choose system clock or the external-select source.
// [RULE_15] control register at 0xc8, bit-addressable, all bits reset to zero.
// [RULE_16] outside split mode a 16-bit overflow loads the 16-bit reload value.
// [RULE_17] in split mode each byte reloads from its own reload byte.
// [RULE_18] capture: each external/8 falling edge copies count to reload, sets high flag.
// [RULE_19] per-byte select one clocks that byte every system clock cycle.
// [RULE_20] a hardware set beats a software clear in the same cycle.

// ==========================================================
// register addresses
`define TT_ADDR_CTRL 8'hc8
`define TT_ADDR_RELOAD_LOW 8'hca
`define TT_ADDR_RELOAD_HIGH 8'hcb
`define TT_ADDR_COUNT_LOW 8'hcc
`define TT_ADDR_COUNT_HIGH 8'hcd

// ==========================================================
// control register fields
`define TT_BIT_HIGH_FLAG 7
`define TT_BIT_LOW_FLAG 6
`define TT_BIT_LOW_IRQ_EN 5
`define TT_BIT_CAPTURE_EN 4
`define TT_BIT_SPLIT 3
`define TT_BIT_RUN 2
`define TT_BIT_UNUSED 1
`define TT_BIT_EXT_SEL 0
`define TT_CTRL_WMASK 8'hfd

// ==========================================================
// reset values
`define TT_RST_CTRL 8'h00
`define TT_RST_BYTE 8'h00

// ==========================================================
// clock divide counts
`define TT_SYS_DIV 12
`define TT_EXT_DIV 8

`endif

// ===== rtl/tt_count_byte.v
/*
 * One 8-bit counter byte of timer two with software write and reload on wrap.
 * Assumes the caller decides when the byte increments and whether a wrap
 * reloads or rolls to zero.
 */
`timescale 1ns/1ns

module tt_count_byte (
   input wire clk_i,
   input wire sys_rst_i,
   input wire wr_i,
   input wire [7:0] wdata_i,
   input wire inc_i,
   input wire reload_i,
   input wire [7:0] reload_val_i,
   output reg [7:0] count_o,
   output wire at_max_o
);

`include "tt_timer_two_map.vh"

   assign at_max_o = (count_o == 8'hff);

   // ==========================================================
   // counter
   // software write wins over counting so a loaded value is not skipped
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         count_o <= `TT_RST_BYTE;
      end else if (wr_i) begin
         count_o <= wdata_i;
      end else if (inc_i) begin
         if (at_max_o && reload_i) begin
            count_o <= reload_val_i; // RULE_17
         end else begin
            count_o <= count_o + 8'h01;
         end
      end
   end

endmodule

// ===== rtl/tt_timer_two.v
/*
 * Timer two: control register, 16-bit or split 8-bit auto-reload counter,
 * reload registers, clock source selection, capture mode and interrupt request.
 * Assumes a special function register bus on clk_i with one-cycle write and
 * read strobes, a bit-write port for the bit-addressable control register,
 * the per-byte clock selects from the clock control register as plain inputs,
 * and the global timer interrupt enable from the interrupt controller.
 */
`timescale 1ns/1ns

`include "tt_timer_two_map.vh"

module tt_timer_two #(
   parameter SYS_DIV = `TT_SYS_DIV,
   parameter EXT_DIV = `TT_EXT_DIV
) (
   input wire clk_i,
   input wire sys_rst_i,
   input wire [7:0] sfr_addr_i,
   input wire sfr_wr_i,
   input wire [7:0] sfr_wdata_i,
   input wire sfr_rd_i,
   output reg [7:0] sfr_rdata_o,
   input wire sfr_bit_wr_i,
   input wire [7:0] sfr_bit_addr_i,
   input wire sfr_bit_val_i,
   input wire high_byte_clock_select_i,
   input wire low_byte_clock_select_i,
   input wire ext_clk_i,
   input wire timer_irq_enable_i,
   output reg high_overflow_o,
   output reg low_overflow_o,
   output wire split_mode_select_o,
   output wire run_control_o,
   output wire capture_mode_enable_o,
   output wire external_clock_select_o,
   output wire irq_o
);

   // counter widths cover the default divides; a larger divide needs a wider count
   localparam DIV_W = 4;
   localparam EXT_W = 3;
   localparam integer SYS_LAST_I = SYS_DIV - 1;
   localparam integer EXT_LAST_I = EXT_DIV - 1;
   localparam [DIV_W-1:0] SYS_LAST = SYS_LAST_I[DIV_W-1:0];
   localparam [EXT_W-1:0] EXT_LAST = EXT_LAST_I[EXT_W-1:0];
   // byte constants held at their width so the slices below stay exact
   localparam [7:0] CTRL_ADDR = `TT_ADDR_CTRL;
   localparam [7:0] RST_CTRL = `TT_RST_CTRL;

   // ==========================================================
   // control register state
   reg high_overflow_flag;
   reg low_overflow_flag;
   reg low_byte_irq_enable;
   reg capture_mode_enable;
   reg split_mode_select;
   reg run_control;
   reg external_clock_select;
   reg [7:0] reload_low_byte;
   reg [7:0] reload_high_byte;
   wire [7:0] counter_low_byte;
   wire [7:0] counter_high_byte;
   wire [7:0] timer_two_control;

   assign timer_two_control = {high_overflow_flag, low_overflow_flag, low_byte_irq_enable,
      capture_mode_enable, split_mode_select, run_control, 1'b0, external_clock_select}; // RULE_11

   assign split_mode_select_o = split_mode_select;
   assign run_control_o = run_control;
   assign capture_mode_enable_o = capture_mode_enable;
   assign external_clock_select_o = external_clock_select;

   // ==========================================================
   // register access decode
   wire wr_ctrl = sfr_wr_i && (sfr_addr_i == `TT_ADDR_CTRL);
   wire wr_rl_low = sfr_wr_i && (sfr_addr_i == `TT_ADDR_RELOAD_LOW);
   wire wr_rl_high = sfr_wr_i && (sfr_addr_i == `TT_ADDR_RELOAD_HIGH);
   wire wr_cnt_low = sfr_wr_i && (sfr_addr_i == `TT_ADDR_COUNT_LOW);
   wire wr_cnt_high = sfr_wr_i && (sfr_addr_i == `TT_ADDR_COUNT_HIGH);
   // bit addresses of the control register are its byte address plus bit index
   // only the control register is bit-addressable here; other bit addresses are ignored
   wire bit_hit = sfr_bit_wr_i && (sfr_bit_addr_i[7:3] == CTRL_ADDR[7:3]); // RULE_15
   wire [2:0] bit_idx = sfr_bit_addr_i[2:0];

   // merged write value for the control register, byte write or single bit
   reg [7:0] ctrl_wval;
   reg ctrl_wen;
   always @* begin
      ctrl_wval = timer_two_control;
      ctrl_wen = 1'b0;
      if (wr_ctrl) begin
         ctrl_wval = sfr_wdata_i & `TT_CTRL_WMASK; // RULE_11
         ctrl_wen = 1'b1;
      end else if (bit_hit) begin
         ctrl_wval[bit_idx] = sfr_bit_val_i;
         ctrl_wen = 1'b1;
      end
   end

   // ==========================================================
   // external clock synchroniser and divide by eight
   reg ext_meta;
   reg ext_sync;
   reg ext_prev;
   reg [EXT_W-1:0] ext_cnt;
   wire ext_rise = ext_sync && !ext_prev;
   // the divided clock is the top count bit; it falls as the count wraps
   wire ext_tick = ext_rise && (ext_cnt == EXT_LAST); // RULE_12

   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ext_meta <= 1'b0;
         ext_sync <= 1'b0;
         ext_prev <= 1'b0;
         ext_cnt <= {EXT_W{1'b0}};
      end else begin
         ext_meta <= ext_clk_i;
         ext_sync <= ext_meta;
         ext_prev <= ext_sync;
         if (ext_rise) begin
            ext_cnt <= ext_cnt + {{(EXT_W-1){1'b0}}, 1'b1};
         end
      end
   end

   // ==========================================================
   // system clock divide by twelve
   reg [DIV_W-1:0] sys_cnt;
   wire sys_tick = (sys_cnt == SYS_LAST);

   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         sys_cnt <= {DIV_W{1'b0}};
      end else if (sys_tick) begin
         sys_cnt <= {DIV_W{1'b0}};
      end else begin
         sys_cnt <= sys_cnt + {{(DIV_W-1){1'b0}}, 1'b1};
      end
   end

   // ==========================================================
   // clock source per byte
   // one external select serves both bytes; per-byte selects override to full rate
   // the external path lags its pin by the synchroniser and the edge detector
   wire slow_tick = external_clock_select ? ext_tick : sys_tick; // RULE_12 RULE_13
   wire low_tick = low_byte_clock_select_i ? 1'b1 : slow_tick; // RULE_14 RULE_19
   wire high_tick = high_byte_clock_select_i ? 1'b1 : slow_tick; // RULE_14 RULE_19

   // ==========================================================
   // counting arrangement
   wire low_at_max;
   wire high_at_max;
   reg low_inc;
   reg high_inc;
   reg low_reload;

   // 16-bit mode: low byte on the low-byte clock, high byte on its carry
   // split mode: two bytes on their own clocks, run gating only the upper one
   always @* begin
      if (split_mode_select) begin // RULE_08
         low_inc = low_tick; // RULE_10
         high_inc = run_control && high_tick; // RULE_10
         low_reload = 1'b1; // RULE_17
      end else begin
         low_inc = run_control && low_tick; // RULE_09
         high_inc = run_control && low_tick && low_at_max;
         low_reload = high_at_max; // RULE_16
      end
   end

   wire low_wrap = low_inc && low_at_max;
   wire high_wrap = high_inc && high_at_max; // RULE_01 RULE_02

   tt_count_byte u_low (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .wr_i(wr_cnt_low),
      .wdata_i(sfr_wdata_i),
      .inc_i(low_inc),
      .reload_i(low_reload),
      .reload_val_i(reload_low_byte),
      .count_o(counter_low_byte),
      .at_max_o(low_at_max)
   );

   // the high byte reloads on every wrap: the full 16-bit wrap, or in split mode its own wrap
   tt_count_byte u_high (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .wr_i(wr_cnt_high),
      .wdata_i(sfr_wdata_i),
      .inc_i(high_inc),
      .reload_i(1'b1),
      .reload_val_i(reload_high_byte),
      .count_o(counter_high_byte),
      .at_max_o(high_at_max)
   );

   // ==========================================================
   // capture event
   // capture samples the counter as it stands before this cycle's increment
   // meant for the 16-bit arrangement; in split mode it still copies both bytes
   wire capture_evt = capture_mode_enable && ext_tick; // RULE_07 RULE_18

   // ==========================================================
   // reload registers
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         reload_low_byte <= `TT_RST_BYTE;
         reload_high_byte <= `TT_RST_BYTE;
      end else if (capture_evt) begin
         reload_low_byte <= counter_low_byte; // RULE_18
         reload_high_byte <= counter_high_byte; // RULE_18
      end else begin
         if (wr_rl_low) begin
            reload_low_byte <= sfr_wdata_i;
         end
         if (wr_rl_high) begin
            reload_high_byte <= sfr_wdata_i;
         end
      end
   end

   // ==========================================================
   // control register and flags
   wire high_set = high_wrap || capture_evt; // RULE_01 RULE_18
   wire low_set = low_wrap; // RULE_05

   // a clear landing with a set leaves the flag set, so no overflow is lost
   wire next_high_flag = high_set ? 1'b1 :
      (ctrl_wen ? ctrl_wval[`TT_BIT_HIGH_FLAG] : high_overflow_flag); // RULE_04 RULE_20
   wire next_low_flag = low_set ? 1'b1 :
      (ctrl_wen ? ctrl_wval[`TT_BIT_LOW_FLAG] : low_overflow_flag); // RULE_04 RULE_20

   // all bits clear on reset; flags only leave one by a software write
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         high_overflow_flag <= RST_CTRL[`TT_BIT_HIGH_FLAG]; // RULE_15
         low_overflow_flag <= RST_CTRL[`TT_BIT_LOW_FLAG];
         low_byte_irq_enable <= RST_CTRL[`TT_BIT_LOW_IRQ_EN];
         capture_mode_enable <= RST_CTRL[`TT_BIT_CAPTURE_EN];
         split_mode_select <= RST_CTRL[`TT_BIT_SPLIT];
         run_control <= RST_CTRL[`TT_BIT_RUN];
         external_clock_select <= RST_CTRL[`TT_BIT_EXT_SEL];
      end else begin
         high_overflow_flag <= next_high_flag;
         low_overflow_flag <= next_low_flag;
         if (ctrl_wen) begin
            low_byte_irq_enable <= ctrl_wval[`TT_BIT_LOW_IRQ_EN];
            capture_mode_enable <= ctrl_wval[`TT_BIT_CAPTURE_EN]; // RULE_07
            split_mode_select <= ctrl_wval[`TT_BIT_SPLIT]; // RULE_08
            run_control <= ctrl_wval[`TT_BIT_RUN]; // RULE_09
            external_clock_select <= ctrl_wval[`TT_BIT_EXT_SEL]; // RULE_12
         end
      end
   end

   // ==========================================================
   // overflow strobes, one cycle after the wrap
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         high_overflow_o <= 1'b0;
         low_overflow_o <= 1'b0;
      end else begin
         high_overflow_o <= high_wrap;
         low_overflow_o <= low_wrap;
      end
   end

   // ==========================================================
   // interrupt request
   // a level held while a serviced flag stays set; software clears the flag
   assign irq_o = timer_irq_enable_i && (high_overflow_flag || // RULE_03
      (low_byte_irq_enable && low_overflow_flag)); // RULE_06

   // ==========================================================
   // read data
   // registered one cycle after the read strobe; unmapped addresses read zero
   // the two count bytes are read one at a time, so a running count is not atomic
   // software wanting a stable 16-bit value stops the timer or reads high twice
   always @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         sfr_rdata_o <= 8'h00;
      end else if (sfr_rd_i) begin
         if (sfr_addr_i == `TT_ADDR_CTRL) begin
            sfr_rdata_o <= timer_two_control; // RULE_11
         end else if (sfr_addr_i == `TT_ADDR_RELOAD_LOW) begin
            sfr_rdata_o <= reload_low_byte;
         end else if (sfr_addr_i == `TT_ADDR_RELOAD_HIGH) begin
            sfr_rdata_o <= reload_high_byte;
         end else if (sfr_addr_i == `TT_ADDR_COUNT_LOW) begin
            sfr_rdata_o <= counter_low_byte;
         end else if (sfr_addr_i == `TT_ADDR_COUNT_HIGH) begin
            sfr_rdata_o <= counter_high_byte;
         end else begin
            sfr_rdata_o <= 8'h00;
         end
      end
   end

endmodule

// ===== tb/tt_timer_two_properties.sv
/*
 * Checker for the timer two control block, seeing only its top ports.
 * Assumes one clock, clk_i, and the asynchronous active-high sys_rst_i.
 */
`timescale 1ns/1ns

module tt_timer_two_properties #(
   parameter SYS_DIV = 12,
   parameter EXT_DIV = 8
) (
   input wire clk_i,
   input wire sys_rst_i,
   input wire [7:0] sfr_addr_i,
   input wire sfr_wr_i,
   input wire [7:0] sfr_wdata_i,
   input wire sfr_rd_i,
   input wire [7:0] sfr_rdata_o,
   input wire sfr_bit_wr_i,
   input wire [7:0] sfr_bit_addr_i,
   input wire sfr_bit_val_i,
   input wire timer_irq_enable_i,
   input wire high_overflow_o,
   input wire low_overflow_o,
   input wire split_mode_select_o,
   input wire run_control_o,
   input wire capture_mode_enable_o,
   input wire external_clock_select_o,
   input wire irq_o
);
   // ==========================================================
   // control writes reach the mode outputs one edge later
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   wire ctl_wr = sfr_wr_i && sfr_addr_i == 8'hc8;
   run_write_a: assert property (ctl_wr |=> run_control_o == $past(sfr_wdata_i[2]))
      else $error("run bit did not follow write");
   split_write_a: assert property (ctl_wr |=> split_mode_select_o == $past(sfr_wdata_i[3]))
      else $error("split bit did not follow write");
   capture_write_a: assert property (ctl_wr |=> capture_mode_enable_o == $past(sfr_wdata_i[4]))
      else $error("capture bit did not follow write");
   ext_write_a: assert property (ctl_wr |=> external_clock_select_o == $past(sfr_wdata_i[0]))
      else $error("clock select did not follow write");
   bit_write_a: assert property (sfr_bit_wr_i && !sfr_wr_i && sfr_bit_addr_i == 8'hca
      |=> run_control_o == $past(sfr_bit_val_i))
      else $error("bit write missed run bit");
   unused_bit_a: assert property (sfr_rd_i && sfr_addr_i == 8'hc8 |=> !sfr_rdata_o[1])
      else $error("unused bit read as one");
   // ==========================================================
   // interrupt and counting relations
   irq_on_high_a: assert property (high_overflow_o && timer_irq_enable_i && !$past(sfr_wr_i)
      && !$past(sfr_bit_wr_i) |-> irq_o)
      else $error("no interrupt on high overflow");
   irq_hold_a: assert property (irq_o && !sfr_wr_i && !sfr_bit_wr_i |=> irq_o || !timer_irq_enable_i)
      else $error("interrupt dropped without a write");
   stopped_a: assert property ((!split_mode_select_o && !run_control_o) [*3]
      |-> !high_overflow_o && !low_overflow_o)
      else $error("overflow while stopped");
   split_high_a: assert property ((split_mode_select_o && !run_control_o) [*3] |-> !high_overflow_o)
      else $error("high byte ran while stopped in split");
   cover property (high_overflow_o && irq_o);
   cover property (low_overflow_o && split_mode_select_o && !run_control_o);
   cover property (capture_mode_enable_o && irq_o);
endmodule

bind tt_timer_two tt_timer_two_properties #(.SYS_DIV(SYS_DIV), .EXT_DIV(EXT_DIV)) u_props (
   .clk_i(clk_i), .sys_rst_i(sys_rst_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
   .sfr_wdata_i(sfr_wdata_i), .sfr_rd_i(sfr_rd_i), .sfr_rdata_o(sfr_rdata_o),
   .sfr_bit_wr_i(sfr_bit_wr_i), .sfr_bit_addr_i(sfr_bit_addr_i), .sfr_bit_val_i(sfr_bit_val_i),
   .timer_irq_enable_i(timer_irq_enable_i), .high_overflow_o(high_overflow_o),
   .low_overflow_o(low_overflow_o), .split_mode_select_o(split_mode_select_o),
   .run_control_o(run_control_o), .capture_mode_enable_o(capture_mode_enable_o),
   .external_clock_select_o(external_clock_select_o), .irq_o(irq_o));

// ===== tb/tt_cpu_model.sv
/*
 * Core side of the register bus: byte write, byte read and bit write tasks.
 * Assumes the timer samples strobes on the rising clk_i edge, one cycle each.
 */
`timescale 1ns/1ns

module tt_cpu_model (
   input wire clk_i,
   output reg [7:0] sfr_addr_o,
   output reg sfr_wr_o,
   output reg [7:0] sfr_wdata_o,
   output reg sfr_rd_o,
   output reg sfr_bit_wr_o,
   output reg [7:0] sfr_bit_addr_o,
   output reg sfr_bit_val_o,
   input wire [7:0] sfr_rdata_i
);
   // ==========================================================
   // idle bus; released lines show inverted values so stale data never matches
   initial begin
      {sfr_addr_o, sfr_wdata_o, sfr_bit_addr_o} = 24'h0;
      {sfr_wr_o, sfr_rd_o, sfr_bit_wr_o, sfr_bit_val_o} = 4'h0;
   end
   task wr(input [7:0] a, input [7:0] d);
      begin
         @(posedge clk_i); #2;
         sfr_addr_o = a; sfr_wdata_o = d; sfr_wr_o = 1'b1;
         @(posedge clk_i); #2;
         sfr_wr_o = 1'b0; sfr_addr_o = ~a; sfr_wdata_o = ~d;
      end
   endtask
   // read data is registered, so it is taken one cycle after the strobe edge
   task rd(input [7:0] a, output [7:0] d);
      begin
         @(posedge clk_i); #2;
         sfr_addr_o = a; sfr_rd_o = 1'b1;
         @(posedge clk_i); #2;
         sfr_rd_o = 1'b0; sfr_addr_o = ~a; d = sfr_rdata_i;
      end
   endtask
   // flags are cleared by writing zero here or by a byte write to 0xc8
   task bwr(input [7:0] a, input v);
      begin
         @(posedge clk_i); #2;
         sfr_bit_addr_o = a; sfr_bit_val_o = v; sfr_bit_wr_o = 1'b1;
         @(posedge clk_i); #2;
         sfr_bit_wr_o = 1'b0; sfr_bit_addr_o = ~a; sfr_bit_val_o = ~v;
      end
   endtask
endmodule

// ===== tb/tt_timer_two_test.sv
/*
 * Self-checking bench for timer two: control bits, wraps, flags, capture.
 * Assumes a 50 MHz clk_i and the core model driving the register bus.
 */
`timescale 1ns/1ns

module tt_timer_two_test;
   reg clk_i = 1'b0;
   reg sys_rst_i = 1'b1;
   reg hsel = 1'b0, lsel = 1'b0, ext_clk = 1'b0, irq_en = 1'b0, ext_run = 1'b0;
   wire [7:0] addr, wdata, baddr, rdata;
   wire wr, rd, bwr, bval, hov, lov, split, run, cap, xsel, irq;
   integer err_count = 0, samples_checked = 0, i, n;
   reg [7:0] v, rh, ctrl_m;

   // ==========================================================
   // clocks; the external source is unrelated in phase to clk_i
   always #10 clk_i = ~clk_i;
   always #37 if (ext_run) ext_clk = ~ext_clk;

   tt_timer_two dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .sfr_addr_i(addr), .sfr_wr_i(wr),
      .sfr_wdata_i(wdata), .sfr_rd_i(rd), .sfr_rdata_o(rdata), .sfr_bit_wr_i(bwr),
      .sfr_bit_addr_i(baddr), .sfr_bit_val_i(bval), .high_byte_clock_select_i(hsel),
      .low_byte_clock_select_i(lsel), .ext_clk_i(ext_clk), .timer_irq_enable_i(irq_en),
      .high_overflow_o(hov), .low_overflow_o(lov), .split_mode_select_o(split), .run_control_o(run),
      .capture_mode_enable_o(cap), .external_clock_select_o(xsel), .irq_o(irq));
   tt_cpu_model cpu (.clk_i(clk_i), .sfr_addr_o(addr), .sfr_wr_o(wr), .sfr_wdata_o(wdata),
      .sfr_rd_o(rd), .sfr_bit_wr_o(bwr), .sfr_bit_addr_o(baddr), .sfr_bit_val_o(bval),
      .sfr_rdata_i(rdata));

   // ==========================================================
   // comparison, read-compare, bounded wait and closing report
   task chk(input [7:0] seen, input [7:0] exp);
      begin
         samples_checked = samples_checked + 1;
         if (seen !== exp) begin
            err_count = err_count + 1;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask
   task rchk(input [7:0] a, input [7:0] exp);
      begin
         cpu.rd(a, v);
         chk(v, exp);
      end
   endtask
   task conclude;
      begin
         $display("checks %0d mismatches %0d", samples_checked, err_count);
         if (err_count == 0 && samples_checked > 0) $display("[ PASS ]");
         else $display("[ FAIL ]");
         $finish;
      end
   endtask
   // which: 0 high strobe, 1 low strobe, 2 interrupt
   task wait_on(input integer lim, input integer which);
      begin
         n = 0;
         while (!(which == 0 ? hov === 1'b1 : which == 1 ? lov === 1'b1 : irq === 1'b1) && n < lim) begin
            @(posedge clk_i); #1;
            n = n + 1;
         end
         if (n >= lim) begin
            chk(8'h00, 8'h01);
            conclude;
         end
      end
   endtask

   // ==========================================================
   // main sequence
   initial begin
      v = $urandom(32'hfabc5c28);
      repeat (8) @(posedge clk_i);
      #2 sys_rst_i = 1'b0;
      // every mapped byte and the unmapped 0xc9 read zero after reset
      for (i = 8; i < 14; i = i + 1) rchk(8'hc0 + i[7:0], 8'h00);
      $display("test reset done");
      rh = $urandom;
      ctrl_m = rh & 8'hfd;
      cpu.wr(8'hc8, rh);
      rchk(8'hc8, ctrl_m);
      chk({4'h0, cap, split, run, xsel}, {4'h0, ctrl_m[4:2], ctrl_m[0]});
      // flip each bit by bit write; bit 1 must stay zero
      for (i = 0; i < 8; i = i + 1) begin
         cpu.bwr(8'hc8 + i[7:0], ~ctrl_m[i]);
         if (i != 1) ctrl_m[i] = ~ctrl_m[i];
         rchk(8'hc8, ctrl_m);
      end
      cpu.wr(8'hc8, 8'h00);
      $display("test control done");
      // 16-bit wrap reloads and sets both flags
      rh = $urandom;
      lsel = 1'b1;
      irq_en = 1'b1;
      cpu.wr(8'hca, 8'h34);
      cpu.wr(8'hcb, rh);
      cpu.wr(8'hcc, 8'hfe);
      cpu.wr(8'hcd, 8'hff);
      cpu.bwr(8'hca, 1'b1);
      wait_on(20, 0);
      chk({7'h0, irq}, 8'h01);
      cpu.bwr(8'hca, 1'b0);
      rchk(8'hc8, 8'hc0);
      rchk(8'hcd, rh);
      // low byte reloaded to 0x34, then counted twice before run dropped
      rchk(8'hcc, 8'h36);
      // low flag alone requests only with the low-byte enable set
      cpu.bwr(8'hcf, 1'b0);
      chk({7'h0, irq}, 8'h00);
      cpu.bwr(8'hcd, 1'b1);
      chk({7'h0, irq}, 8'h01);
      cpu.bwr(8'hce, 1'b0);
      chk({7'h0, irq}, 8'h00);
      $display("test wrap done");
      // split with run off: low byte counts, high byte holds
      hsel = 1'b1;
      cpu.wr(8'hcc, 8'hfe);
      cpu.wr(8'hcd, 8'hfe);
      cpu.wr(8'hca, 8'ha5);
      cpu.wr(8'hc8, 8'h08);
      wait_on(20, 1);
      // low byte reloaded to 0xa5 and has counted once when the read is taken
      rchk(8'hcc, 8'ha6);
      rchk(8'hcd, 8'hfe);
      rchk(8'hc8, 8'h48);
      chk({7'h0, irq}, 8'h00);
      cpu.wr(8'hc8, 8'h00);
      $display("test split done");
      // capture on the divided external clock copies the held count
      lsel = 1'b0;
      cpu.wr(8'hca, 8'h77);
      cpu.wr(8'hcb, 8'h77);
      cpu.wr(8'hcc, 8'h00);
      cpu.wr(8'hcd, 8'h00);
      cpu.wr(8'hc8, 8'h11);
      ext_run = 1'b1;
      wait_on(2000, 2);
      ext_run = 1'b0;
      rchk(8'hca, 8'h00);
      rchk(8'hcb, 8'h00);
      rchk(8'hc8, 8'h91);
      $display("test capture done");
      // a reset in mid-run clears flags and control bits again
      sys_rst_i = 1'b1;
      repeat (2) @(posedge clk_i);
      #2 sys_rst_i = 1'b0;
      rchk(8'hc8, 8'h00);
      $display("test reset again done");
      conclude;
   end
endmodule
